// File: shared/ssmx_pkg.sv
// Package: constants, encodings and register map of the state-move executor
package ssmx_pkg;

  // Instruction field positions
  localparam int unsigned F_RT_LSB = 0;     // Register index field [4:0]
  localparam int unsigned F_OP2_LSB = 5;    // Second opcode [7:5]
  localparam int unsigned F_CRM_LSB = 8;    // m-field [11:8]
  localparam int unsigned F_CRN_LSB = 12;   // n-field [15:12]
  localparam int unsigned F_OP1_LSB = 16;   // First opcode [18:16]
  localparam int unsigned F_O0_BIT = 19;    // Space-select bit
  localparam int unsigned F_DIR_BIT = 21;   // Direction bit (0 = write)

  // Fixed opcode patterns
  localparam logic [12:0] IMM_TOP = 13'h1AA0;   // Bits [31:19] of the immediate form
  localparam logic [3:0] IMM_CRN = 4'h4;        // Bits [15:12] of the immediate form
  localparam logic [4:0] IMM_RT = 5'h1F;        // Bits [4:0] of the immediate form
  localparam logic [11:0] REG_TOP = 12'hD51;    // Bits [31:20] single-register write
  localparam logic [11:0] PAIR_TOP = 12'hD55;   // Bits [31:20] register-pair write

  // First/second opcode combinations of the immediate form
  localparam logic [5:0] SEL_UAO = 6'h03;
  localparam logic [5:0] SEL_PAN = 6'h04;
  localparam logic [5:0] SEL_SP = 6'h05;
  localparam logic [5:0] SEL_ALLPM = 6'h08;
  localparam logic [5:0] SEL_SPECULATIVE_BYPASS_SAFE = 6'h19;
  localparam logic [5:0] SEL_DIT = 6'h1A;
  localparam logic [5:0] SEL_TCO = 6'h1C;
  localparam logic [5:0] SEL_MSET = 6'h1E;
  localparam logic [5:0] SEL_MCLR = 6'h1F;

  // Privilege levels and space base
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;
  localparam logic [1:0] LVL_MON = 2'h3;
  localparam logic [1:0] SPACE_BASE = 2'h2;

  // Exception syndrome
  localparam logic [5:0] CLASS_SYSTRAP = 6'h18;

  // Processor-state flag slots
  localparam int unsigned NFLAG = 8;
  localparam int unsigned FL_SP = 0;
  localparam int unsigned FL_PAN = 1;
  localparam int unsigned FL_UAO = 2;
  localparam int unsigned FL_DIT = 3;
  localparam int unsigned FL_TCO = 4;
  localparam int unsigned FL_SPECULATIVE_BYPASS_SAFE = 5;
  localparam int unsigned FL_ALL_INTERRUPT_MASK = 6;
  localparam int unsigned FL_PM = 7;
  localparam logic [7:0] FLAG_RST = 8'h01;   // Stack select starts at 1
  localparam logic [3:0] MASK_RST = 4'hF;    // All four exception masks set

  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam logic [31:0] CTRL_RST = 32'h00003FE1;

  // Control register fields
  localparam int unsigned C_LVL_LSB = 0;
  localparam int unsigned C_SECURE = 2;
  localparam int unsigned C_HCFG_EN = 3;
  localparam int unsigned C_TRAP_ALL_INT_MASK_WRITE = 4;
  localparam int unsigned C_VHE = 5;
  localparam int unsigned C_SR128 = 6;
  localparam int unsigned C_NMI = 7;
  localparam int unsigned C_EBEP = 8;
  localparam int unsigned C_UAO = 9;
  localparam int unsigned C_PAN = 10;
  localparam int unsigned C_DIT = 11;
  localparam int unsigned C_MTE = 12;
  localparam int unsigned C_SPECULATIVE_BYPASS_SAFE = 13;

  // Status register fields
  localparam int unsigned S_MASK_LSB = 0;
  localparam int unsigned S_FLAG_LSB = 4;

  // Decoded instruction form
  typedef enum logic [1:0] {
    SSMX_FORM_OTHER,
    SSMX_FORM_IMM,
    SSMX_FORM_REG,
    SSMX_FORM_PAIR
  } ssmx_form_t;

endpackage : ssmx_pkg

// File: shared/ssmx_flag_if.sv
// Interface: write strobes and state of the processor-state flag bank
`timescale 1ns/1ps
interface ssmx_flag_if;
  logic [ssmx_pkg::NFLAG-1:0] wr_en;  // One strobe per flag
  logic wr_val;                       // Value written to every strobed flag
  logic [ssmx_pkg::NFLAG-1:0] state;  // Current flag values

  modport owner (input wr_en, input wr_val, output state);
  modport user (output wr_en, output wr_val, input state);
endinterface : ssmx_flag_if

// File: hdl/ssmx_flag_bank.sv
// Module: bank of single-bit processor-state flags with per-bit write strobes
`timescale 1ns/1ps
module ssmx_flag_bank #(
  parameter int unsigned N = 8,
  parameter logic [N-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Flag access
  ssmx_flag_if.owner flags
);

  // One flop per flag; only strobed bits change
  for (genvar g = 0; g < N; g++) begin : g_flag
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        flags.state[g] <= RST_VAL[g];
      end else if (flags.wr_en[g]) begin
        flags.state[g] <= flags.wr_val;
      end
    end
  end

endmodule : ssmx_flag_bank

// File: hdl/ssmx_top.sv
// Module: decode and execution of the processor-state and system-register write forms
//
// Contract
// RQ1 - Mask-set ORs immediate bits into masks
// RQ2 - Mask-clear clears masks where immediate bit set
// RQ3 - Stack select loads immediate bit 0
// RQ4 - Single flags written from immediate bit 0
// RQ5 - Unprivileged override written from immediate bit 0
// RQ6 - All-interrupt write traps under hypervisor control
// RQ7 - Register write sends full 64-bit source
// RQ8 - Target chosen by space:op1:n:m:op2
// RQ9 - Register space is two plus space bit
// RQ10 - Opcode fields are 3-bit unsigned
// RQ11 - n and m selectors are 4-bit
// RQ12 - Access check precedes every register write
// RQ13 - Pair undefined without feature or odd index
// RQ14 - Pair writes 128 bits from two registers
// RQ15 - Second source index is index plus one
// RQ16 - Opcodes 011/110 select mask-set
// RQ17 - Opcodes 011/111 select mask-clear
// RQ18 - Opcodes 000/101 select stack select
// RQ19 - Undefined below minimum level or non-secure
// RQ20 - Faults signal exception, change no state
// RQ21 - Pipeline presents word and sources together
`timescale 1ns/1ps
module ssmx_top (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // APB register port
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Instruction from the pipeline
  input wire logic I_INSTR_VALID,
  input wire logic [31:0] I_INSTR,
  input wire logic [63:0] I_SRC_LO,
  input wire logic [63:0] I_SRC_HI,
  output logic [4:0] O_SRC_LO_IDX,
  output logic [4:0] O_SRC_HI_IDX,
  // Access checks answered by the exception unit in the same cycle
  output logic O_CHK_REQ,
  output logic [14:0] O_CHK_ENC,
  output logic [4:0] O_CHK_IDX,
  output logic O_CHK_DIR,
  output logic O_MCHK_REQ,
  input wire logic I_CHK_DENY,
  input wire logic I_MCHK_DENY,
  input wire logic [5:0] I_CHK_CLASS,
  input wire logic [1:0] I_CHK_LEVEL,
  // Completion and exception report
  output logic O_DONE,
  output logic O_EXC_VALID,
  output logic O_EXC_UNDEF,
  output logic O_EXC_TRAP,
  output logic [5:0] O_EXC_CLASS,
  output logic [1:0] O_EXC_LEVEL,
  // System register file write
  output logic O_SR_WR,
  output logic O_SR_PAIR,
  output logic [1:0] O_SR_SPACE,
  output logic [14:0] O_SR_ENC,
  output logic [127:0] O_SR_WDATA,
  // Processor state
  output logic [3:0] O_MASKS,
  output logic [ssmx_pkg::NFLAG-1:0] O_FLAGS
);

  // Instruction fields
  logic o0;              // Space-select bit
  logic [2:0] op1;       // First opcode, 0..7
  logic [2:0] op2;       // Second opcode, 0..7
  logic [3:0] crn;       // n-field, 0..15
  logic [3:0] crm;       // m-field and 4-bit immediate, 0..15
  logic [4:0] rt;        // Register index
  logic [5:0] opsel;     // op1:op2 for the immediate form
  ssmx_pkg::ssmx_form_t form;

  // Configuration and state
  logic [31:0] ctrl;     // Software controlled level, security and features
  logic [3:0] masks;     // Debug, SError, IRQ, FIQ masks (bits 3..0)
  logic [15:0] wr_count; // Completed writes
  logic [15:0] exc_count;// Raised exceptions
  logic [1:0] cur_lvl;

  // Decode results
  logic undef;
  logic trap;
  logic [5:0] trap_class;
  logic [1:0] trap_lvl;
  logic [1:0] min_lvl;
  logic need_secure;
  logic sr_go;
  logic mask_go;
  logic [3:0] next_masks;
  logic [ssmx_pkg::NFLAG-1:0] flag_wr;
  logic commit;          // Instruction completes without a fault

  ssmx_flag_if flag_bus ();

  // Field extraction; widths fix the opcode and selector ranges
  assign o0 = I_INSTR[ssmx_pkg::F_O0_BIT];
  assign op1 = I_INSTR[ssmx_pkg::F_OP1_LSB +: 3];  // see RQ10
  assign op2 = I_INSTR[ssmx_pkg::F_OP2_LSB +: 3];  // see RQ10
  assign crn = I_INSTR[ssmx_pkg::F_CRN_LSB +: 4];  // see RQ11
  assign crm = I_INSTR[ssmx_pkg::F_CRM_LSB +: 4];  // see RQ11
  assign rt = I_INSTR[ssmx_pkg::F_RT_LSB +: 5];
  assign opsel = {op1, op2};
  assign cur_lvl = ctrl[ssmx_pkg::C_LVL_LSB +: 2];

  // Source indices the pipeline reads; pair partner is index plus one
  assign O_SRC_LO_IDX = rt;
  assign O_SRC_HI_IDX = rt + 5'h01;  // see RQ15

  // Form recognition on the fixed opcode bits
  always_comb begin
    if (I_INSTR[31:19] == ssmx_pkg::IMM_TOP && crn == ssmx_pkg::IMM_CRN &&
        rt == ssmx_pkg::IMM_RT) begin
      form = ssmx_pkg::SSMX_FORM_IMM;
    end else if (I_INSTR[31:20] == ssmx_pkg::REG_TOP) begin
      form = ssmx_pkg::SSMX_FORM_REG;
    end else if (I_INSTR[31:20] == ssmx_pkg::PAIR_TOP) begin
      form = ssmx_pkg::SSMX_FORM_PAIR;
    end else begin
      form = ssmx_pkg::SSMX_FORM_OTHER;
    end
  end

  // Minimum privilege per first opcode for the immediate form
  always_comb begin
    need_secure = 1'b0;
    case (op1)
      3'h0, 3'h1, 3'h2: begin
        min_lvl = ssmx_pkg::LVL_KERNEL;
      end
      3'h3: begin
        min_lvl = ssmx_pkg::LVL_USER;
      end
      3'h4, 3'h5: begin
        min_lvl = ssmx_pkg::LVL_HYP;
      end
      3'h6: begin
        min_lvl = ssmx_pkg::LVL_MON;
      end
      default: begin
        min_lvl = ssmx_pkg::LVL_KERNEL;
        need_secure = 1'b1;
      end
    endcase
  end

  // Access check requests go out combinationally; the answer returns this cycle
  assign O_CHK_REQ = I_INSTR_VALID && form != ssmx_pkg::SSMX_FORM_OTHER;  // see RQ12
  assign O_CHK_ENC = {o0, op1, crn, crm, op2};  // see RQ8
  assign O_CHK_IDX = rt;
  assign O_CHK_DIR = I_INSTR[ssmx_pkg::F_DIR_BIT];
  assign O_MCHK_REQ = I_INSTR_VALID && form == ssmx_pkg::SSMX_FORM_IMM &&
                      (opsel == ssmx_pkg::SEL_MSET || opsel == ssmx_pkg::SEL_MCLR);

  // Main decode: fault classification and the effect of a clean instruction
  always_comb begin
    undef = 1'b0;
    trap = 1'b0;
    trap_class = I_CHK_CLASS;
    trap_lvl = I_CHK_LEVEL;
    sr_go = 1'b0;
    mask_go = 1'b0;
    next_masks = masks;
    flag_wr = '0;
    case (form)
      ssmx_pkg::SSMX_FORM_IMM: begin
        // Level and security gate comes before field selection
        if (cur_lvl < min_lvl || (need_secure && !ctrl[ssmx_pkg::C_SECURE])) begin
          undef = 1'b1;  // see RQ19
        end else if (op1 == 3'h5 && !ctrl[ssmx_pkg::C_VHE]) begin
          undef = 1'b1;
        end else if (I_CHK_DENY) begin
          trap = 1'b1;
        end else begin
          case (opsel)
            ssmx_pkg::SEL_SP: begin
              flag_wr[ssmx_pkg::FL_SP] = 1'b1;  // see RQ18 see RQ3
            end
            ssmx_pkg::SEL_UAO: begin
              undef = !ctrl[ssmx_pkg::C_UAO];
              flag_wr[ssmx_pkg::FL_UAO] = ctrl[ssmx_pkg::C_UAO];  // see RQ5
            end
            ssmx_pkg::SEL_PAN: begin
              undef = !ctrl[ssmx_pkg::C_PAN];
              flag_wr[ssmx_pkg::FL_PAN] = ctrl[ssmx_pkg::C_PAN];  // see RQ4
            end
            ssmx_pkg::SEL_DIT: begin
              undef = !ctrl[ssmx_pkg::C_DIT];
              flag_wr[ssmx_pkg::FL_DIT] = ctrl[ssmx_pkg::C_DIT];  // see RQ4
            end
            ssmx_pkg::SEL_TCO: begin
              undef = !ctrl[ssmx_pkg::C_MTE];
              flag_wr[ssmx_pkg::FL_TCO] = ctrl[ssmx_pkg::C_MTE];  // see RQ4
            end
            ssmx_pkg::SEL_SPECULATIVE_BYPASS_SAFE: begin
              undef = !ctrl[ssmx_pkg::C_SPECULATIVE_BYPASS_SAFE];
              flag_wr[ssmx_pkg::FL_SPECULATIVE_BYPASS_SAFE] = ctrl[ssmx_pkg::C_SPECULATIVE_BYPASS_SAFE];  // see RQ4
            end
            ssmx_pkg::SEL_ALLPM: begin
              // Upper m-field bits pick all-interrupt mask or monitor mask
              if (crm[3:1] == 3'h0 && ctrl[ssmx_pkg::C_NMI]) begin
                if (cur_lvl == ssmx_pkg::LVL_KERNEL && ctrl[ssmx_pkg::C_HCFG_EN] &&
                    ctrl[ssmx_pkg::C_TRAP_ALL_INT_MASK_WRITE] && crm[0]) begin
                  trap = 1'b1;  // see RQ6
                  trap_class = ssmx_pkg::CLASS_SYSTRAP;
                  trap_lvl = ssmx_pkg::LVL_HYP;
                end else begin
                  flag_wr[ssmx_pkg::FL_ALL_INTERRUPT_MASK] = 1'b1;  // see RQ6
                end
              end else if (crm[3:1] == 3'h1 && ctrl[ssmx_pkg::C_EBEP]) begin
                flag_wr[ssmx_pkg::FL_PM] = 1'b1;  // see RQ4
              end else begin
                undef = 1'b1;
              end
            end
            ssmx_pkg::SEL_MSET: begin
              // Mask access check first, then OR the immediate in
              if (I_MCHK_DENY) begin
                trap = 1'b1;
              end else begin
                mask_go = 1'b1;  // see RQ16
                next_masks = masks | crm;  // see RQ1
              end
            end
            ssmx_pkg::SEL_MCLR: begin
              if (I_MCHK_DENY) begin
                trap = 1'b1;
              end else begin
                mask_go = 1'b1;  // see RQ17
                next_masks = masks & ~crm;  // see RQ2
              end
            end
            default: begin
              // Reserved and unsupported selections, flag-manipulation forms too
              undef = 1'b1;
            end
          endcase
        end
      end
      ssmx_pkg::SSMX_FORM_REG: begin
        if (I_CHK_DENY) begin
          trap = 1'b1;  // see RQ12
        end else begin
          sr_go = 1'b1;
        end
      end
      ssmx_pkg::SSMX_FORM_PAIR: begin
        // Feature and alignment are decode faults and beat the access check
        if (!ctrl[ssmx_pkg::C_SR128] || rt[0]) begin
          undef = 1'b1;  // see RQ13
        end else if (I_CHK_DENY) begin
          trap = 1'b1;  // see RQ12
        end else begin
          sr_go = 1'b1;
        end
      end
      default: begin
        undef = 1'b1;
      end
    endcase
  end

  // A fault suppresses every state write
  assign commit = I_INSTR_VALID && !undef && !trap;  // see RQ20

  // Flag bank writes only on a clean immediate instruction
  assign flag_bus.wr_en = commit ? flag_wr : '0;  // see RQ20
  assign flag_bus.wr_val = crm[0];  // see RQ3 see RQ4 see RQ5

  ssmx_flag_bank #(
    .N(ssmx_pkg::NFLAG),
    .RST_VAL(ssmx_pkg::FLAG_RST)
  ) u_flags (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .flags(flag_bus.owner)
  );

  assign O_FLAGS = flag_bus.state;
  assign O_MASKS = masks;

  // Exception masks
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      masks <= ssmx_pkg::MASK_RST;
    end else if (commit && mask_go) begin
      masks <= next_masks;  // see RQ1 see RQ2
    end
  end

  // Completion and exception report, one cycle after the instruction
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_DONE <= 1'b0;
      O_EXC_VALID <= 1'b0;
      O_EXC_UNDEF <= 1'b0;
      O_EXC_TRAP <= 1'b0;
      O_EXC_CLASS <= 6'h00;
      O_EXC_LEVEL <= 2'h0;
    end else begin
      O_DONE <= I_INSTR_VALID;
      O_EXC_VALID <= I_INSTR_VALID && (undef || trap);  // see RQ20
      O_EXC_UNDEF <= I_INSTR_VALID && undef;
      O_EXC_TRAP <= I_INSTR_VALID && trap && !undef;
      O_EXC_CLASS <= (I_INSTR_VALID && trap && !undef) ? trap_class : 6'h00;
      O_EXC_LEVEL <= (I_INSTR_VALID && trap && !undef) ? trap_lvl : 2'h0;
    end
  end

  // System register write port; data held until the next write
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_SR_WR <= 1'b0;
      O_SR_PAIR <= 1'b0;
      O_SR_SPACE <= 2'h0;
      O_SR_ENC <= 15'h0000;
      O_SR_WDATA <= 128'h0;
    end else begin
      O_SR_WR <= commit && sr_go;
      O_SR_PAIR <= commit && sr_go && form == ssmx_pkg::SSMX_FORM_PAIR;
      if (commit && sr_go) begin
        O_SR_SPACE <= ssmx_pkg::SPACE_BASE + {1'b0, o0};  // see RQ9
        O_SR_ENC <= {o0, op1, crn, crm, op2};  // see RQ8
        if (form == ssmx_pkg::SSMX_FORM_PAIR) begin
          O_SR_WDATA <= {I_SRC_HI, I_SRC_LO};  // see RQ14 see RQ21
        end else begin
          O_SR_WDATA <= {64'h0, I_SRC_LO};  // see RQ7
        end
      end
    end
  end

  // Activity counters, wrap silently
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      wr_count <= 16'h0000;
      exc_count <= 16'h0000;
    end else begin
      if (commit) begin
        wr_count <= wr_count + 16'h0001;
      end
      if (I_INSTR_VALID && (undef || trap)) begin
        exc_count <= exc_count + 16'h0001;
      end
    end
  end

  // APB: zero wait states; reads are captured in the setup cycle
  logic apb_setup;
  logic apb_access;
  logic addr_ok;

  assign apb_setup = I_PSEL && !I_PENABLE;
  assign apb_access = I_PSEL && I_PENABLE;
  assign addr_ok = I_PADDR == ssmx_pkg::ADDR_CTRL || I_PADDR == ssmx_pkg::ADDR_STATUS ||
                   I_PADDR == ssmx_pkg::ADDR_COUNT;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = apb_access && !addr_ok;

  // Control register, byte lanes honoured; status and counters are read-only
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      ctrl <= ssmx_pkg::CTRL_RST;
    end else if (apb_access && I_PWRITE && I_PADDR == ssmx_pkg::ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (I_PSTRB[b]) begin
          ctrl[b*8 +: 8] <= I_PWDATA[b*8 +: 8];
        end
      end
    end
  end

  // Read data register; unmapped addresses read zero
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_PRDATA <= 32'h00000000;
    end else if (apb_setup) begin
      case (I_PADDR)
        ssmx_pkg::ADDR_CTRL: begin
          O_PRDATA <= ctrl;
        end
        ssmx_pkg::ADDR_STATUS: begin
          O_PRDATA <= {20'h00000, flag_bus.state, masks};
        end
        ssmx_pkg::ADDR_COUNT: begin
          O_PRDATA <= {exc_count, wr_count};
        end
        default: begin
          O_PRDATA <= 32'h00000000;
        end
      endcase
    end
  end

endmodule : ssmx_top

// File: verif/ssmx_top_assertions.sv
// Checker: port-level rules of the state-move executor
`timescale 1ns/1ps
module ssmx_top_assertions (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // Instruction side
  input wire logic I_INSTR_VALID,
  input wire logic [31:0] I_INSTR,
  input wire logic [63:0] I_SRC_LO,
  input wire logic I_CHK_DENY,
  input wire logic [4:0] O_SRC_LO_IDX,
  input wire logic [4:0] O_SRC_HI_IDX,
  input wire logic O_CHK_REQ,
  // Results
  input wire logic O_EXC_VALID,
  input wire logic O_EXC_UNDEF,
  input wire logic O_SR_WR,
  input wire logic O_SR_PAIR,
  input wire logic [1:0] O_SR_SPACE,
  input wire logic [14:0] O_SR_ENC,
  input wire logic [127:0] O_SR_WDATA,
  input wire logic [3:0] O_MASKS,
  input wire logic [ssmx_pkg::NFLAG-1:0] O_FLAGS
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_SYS_RST);
  // Issue-cycle decode; a fault in the answer cycle excuses a missing update
  wire logic imm = I_INSTR_VALID && I_INSTR[31:19] == ssmx_pkg::IMM_TOP
    && I_INSTR[15:12] == ssmx_pkg::IMM_CRN && I_INSTR[4:0] == ssmx_pkg::IMM_RT;
  wire logic [5:0] sel = {I_INSTR[18:16], I_INSTR[7:5]};
  wire logic rform = I_INSTR_VALID && I_INSTR[31:20] == ssmx_pkg::REG_TOP;
  wire logic pform = I_INSTR_VALID && I_INSTR[31:20] == ssmx_pkg::PAIR_TOP;

  mask_set_a: assert property (imm && sel == ssmx_pkg::SEL_MSET ##1 !O_EXC_VALID
    |-> O_MASKS == ($past(O_MASKS) | $past(I_INSTR[11:8]))) else $error("Mask set wrong");
  mask_clear_a: assert property (imm && sel == ssmx_pkg::SEL_MCLR ##1 !O_EXC_VALID
    |-> O_MASKS == ($past(O_MASKS) & ~$past(I_INSTR[11:8]))) else $error("Mask clear wrong");
  stack_load_a: assert property (imm && sel == ssmx_pkg::SEL_SP ##1 !O_EXC_VALID
    |-> O_FLAGS[ssmx_pkg::FL_SP] == $past(I_INSTR[8])) else $error("Stack select wrong");
  fault_still_a: assert property (O_EXC_VALID
    |-> $stable(O_MASKS) && $stable(O_FLAGS) && !O_SR_WR) else $error("State moved on fault");
  space_num_a: assert property (O_SR_WR
    |-> O_SR_SPACE == 2'h2 + {1'b0, O_SR_ENC[14]}) else $error("Space number wrong");
  target_enc_a: assert property ((rform || pform) ##1 O_SR_WR
    |-> O_SR_ENC == $past(I_INSTR[19:5])) else $error("Target encoding wrong");
  single_data_a: assert property (rform ##1 O_SR_WR
    |-> !O_SR_PAIR && O_SR_WDATA == {64'h0, $past(I_SRC_LO)}) else $error("Single data wrong");
  odd_pair_a: assert property (pform && I_INSTR[0]
    |=> O_EXC_UNDEF && !O_SR_WR) else $error("Odd pair not undefined");
  hi_index_a: assert property (I_INSTR_VALID
    |-> O_SRC_HI_IDX == O_SRC_LO_IDX + 5'h1) else $error("Second index wrong");
  deny_trap_a: assert property (I_INSTR_VALID && O_CHK_REQ && I_CHK_DENY
    |=> O_EXC_VALID && !O_SR_WR) else $error("Denied write went through");

  // Main scenarios reached
  cover property (imm && sel == ssmx_pkg::SEL_MSET ##1 !O_EXC_VALID);
  cover property (pform ##1 O_SR_WR && O_SR_PAIR);
  cover property (I_INSTR_VALID && I_CHK_DENY ##1 O_EXC_VALID);
endmodule : ssmx_top_assertions

// File: verif/ssmx_pipe_model.sv
// Model: pipeline register file and exception unit facing the executor
`timescale 1ns/1ps
module ssmx_pipe_model (
  // Control from the bench
  input wire logic i_deny,
  // Requests from the executor
  input wire logic i_valid,
  input wire logic i_chk_req,
  input wire logic i_mchk_req,
  input wire logic [4:0] i_lo_idx,
  input wire logic [4:0] i_hi_idx,
  // Answers
  output logic [63:0] o_src_lo,
  output logic [63:0] o_src_hi,
  output logic o_chk_deny,
  output logic o_mchk_deny,
  output logic [5:0] o_class,
  output logic [1:0] o_level
);
  // The low source holds its index per byte, the high source its complement; off-issue the values are scrambled
  always_comb begin
    o_src_lo = {8{3'h0, i_lo_idx}} ^ {64{~i_valid}};
    o_src_hi = ~{8{3'h0, i_hi_idx}} ^ {64{~i_valid}};
    o_chk_deny = i_chk_req & i_deny;
    o_mchk_deny = i_mchk_req & i_deny;
    o_class = 6'h18;
    o_level = 2'h2;
  end
endmodule : ssmx_pipe_model

// File: verif/ssmx_top_bench.sv
// Testbench: register access and instruction sequences for the state-move executor
`timescale 1ns/1ps
module ssmx_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, valid = 1'b0, deny = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] src_lo, src_hi;
  logic [4:0] lo_idx, hi_idx;
  logic chk_req, mchk_req, chk_deny, mchk_deny, done, exc, undef, trap, sr_wr, sr_pair;
  logic [5:0] cls, exc_cls;
  logic [1:0] lvl, exc_lvl, space;
  logic [14:0] enc;
  logic [127:0] wdata;
  logic [3:0] masks;
  logic [7:0] flags;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [5:0] sels[6] = '{ssmx_pkg::SEL_SP, ssmx_pkg::SEL_PAN, ssmx_pkg::SEL_UAO,
    ssmx_pkg::SEL_DIT, ssmx_pkg::SEL_TCO, ssmx_pkg::SEL_SPECULATIVE_BYPASS_SAFE};
  int slots[6] = '{0, 1, 2, 3, 4, 5};

  always #10 clk = ~clk;

  ssmx_top ssmx_top_inst (.I_MCLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_SRC_LO(src_lo), .I_SRC_HI(src_hi), .O_SRC_LO_IDX(lo_idx), .O_SRC_HI_IDX(hi_idx),
    .O_CHK_REQ(chk_req), .O_CHK_ENC(), .O_CHK_IDX(), .O_CHK_DIR(), .O_MCHK_REQ(mchk_req),
    .I_CHK_DENY(chk_deny), .I_MCHK_DENY(mchk_deny), .I_CHK_CLASS(cls), .I_CHK_LEVEL(lvl),
    .O_DONE(done), .O_EXC_VALID(exc), .O_EXC_UNDEF(undef), .O_EXC_TRAP(trap),
    .O_EXC_CLASS(exc_cls), .O_EXC_LEVEL(exc_lvl), .O_SR_WR(sr_wr), .O_SR_PAIR(sr_pair),
    .O_SR_SPACE(space), .O_SR_ENC(enc), .O_SR_WDATA(wdata), .O_MASKS(masks), .O_FLAGS(flags));

  ssmx_pipe_model ssmx_pipe_model_inst (.i_deny(deny), .i_valid(valid), .i_chk_req(chk_req),
    .i_mchk_req(mchk_req), .i_lo_idx(lo_idx), .i_hi_idx(hi_idx), .o_src_lo(src_lo),
    .o_src_hi(src_hi), .o_chk_deny(chk_deny), .o_mchk_deny(mchk_deny), .o_class(cls),
    .o_level(lvl));

  // Counts a value against its expectation
  // Wide enough for the packed strobe, space, encoding and 128-bit data compares
  task automatic chk(input string nm, input logic [159:0] e, input logic [159:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issues one instruction; results are sampled once the answer edge has landed
  task automatic exec(input logic [31:0] w);
    @(posedge clk);
    valid <= 1'b1;
    instr <= w;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk("done", 1, done);
  endtask : exec

  function automatic logic [31:0] imm_w(input logic [5:0] s, input logic [3:0] m);
    return {ssmx_pkg::IMM_TOP, s[5:3], ssmx_pkg::IMM_CRN, m, s[2:0], ssmx_pkg::IMM_RT};
  endfunction : imm_w

  task automatic finish_test;
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Watchdog against a hung handshake
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ssmx_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", ssmx_pkg::CTRL_RST, rd);
    apb(1'b1, ssmx_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, ssmx_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h01F, rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", 1, er);
    exec(imm_w(ssmx_pkg::SEL_MCLR, 4'h5));
    chk("masks", 4'hA, masks);
    exec(imm_w(ssmx_pkg::SEL_MSET, 4'h1));
    chk("masks", 4'hB, masks);
    // Odd immediates set the flag, even ones with high bits clear it
    for (int i = 0; i < 6; i++) begin
      exec(imm_w(sels[i], 4'h1));
      chk("flag set", 1, flags[slots[i]]);
      exec(imm_w(sels[i], 4'hE));
      chk("flag clear", 0, flags[slots[i]]);
    end
    exec(imm_w(ssmx_pkg::SEL_ALLPM, 4'h3));
    chk("monitor mask", 1, flags[ssmx_pkg::FL_PM]);
    apb(1'b1, ssmx_pkg::ADDR_CTRL, 32'h00003FF9);
    exec(imm_w(ssmx_pkg::SEL_ALLPM, 4'h1));
    chk("trap", 1, trap);
    chk("class", {2'h2, 6'h18}, {exc_lvl, exc_cls});
    chk("kept", 0, flags[ssmx_pkg::FL_ALL_INTERRUPT_MASK]);
    exec(imm_w(ssmx_pkg::SEL_ALLPM, 4'h0));
    chk("no trap", 0, exc);
    apb(1'b1, ssmx_pkg::ADDR_CTRL, 32'h00003FE0);
    exec(imm_w(ssmx_pkg::SEL_PAN, 4'h1));
    chk("low level", 1, undef);
    apb(1'b1, ssmx_pkg::ADDR_CTRL, ssmx_pkg::CTRL_RST);
    for (int o = 0; o < 2; o++) begin
      exec({ssmx_pkg::REG_TOP, o[0], 3'h7, 4'hF, 4'h2, 3'h1, 5'h05});
      chk("single", {1'b1, 2'h2 + o[1:0], o[0], 3'h7, 4'hF, 4'h2, 3'h1, 64'h0,
        {8{8'h05}}}, {sr_wr, space, enc, wdata});
    end
    exec({ssmx_pkg::PAIR_TOP, 15'h4C21, 5'h04});
    chk("pair", {2'h3, ~{8{8'h05}}, {8{8'h04}}}, {sr_wr, sr_pair, wdata});
    exec({ssmx_pkg::PAIR_TOP, 15'h4C21, 5'h03});
    chk("odd pair", 2'h2, {undef, sr_wr});
    apb(1'b1, ssmx_pkg::ADDR_CTRL, 32'h00003FA1);
    exec({ssmx_pkg::PAIR_TOP, 15'h4C21, 5'h04});
    chk("no feature", 2'h2, {undef, sr_wr});
    deny <= 1'b1;
    exec({ssmx_pkg::REG_TOP, 15'h4C21, 5'h05});
    chk("denied", 2'h2, {trap, sr_wr});
    exec(imm_w(ssmx_pkg::SEL_MCLR, 4'hF));
    chk("masks kept", 4'hB, masks);
    finish_test();
  end
endmodule : ssmx_top_bench

bind ssmx_top ssmx_top_assertions ssmx_top_assertions_inst (.*);
